// ==== shared/coovl_pkg.sv ====
package coovl_pkg;
  localparam logic [7:0]  CMD_OFFSET_TRIM  = 8'h39;
  localparam logic [7:0]  CMD_OV_LIMIT     = 8'h40;
  localparam logic [7:0]  PHASE_ALL        = 8'hff;
  localparam logic [7:0]  PHASE_LAST       = 8'h03;

  // offset trim word layout
  localparam int          TRIM_EXP_HI      = 15;
  localparam int          TRIM_EXP_LO      = 11;
  localparam int          TRIM_MAN_HI      = 10;
  localparam int          TRIM_MAN_W       = 11;
  localparam logic [4:0]  TRIM_EXP_FIXED   = 5'h1c;

  // response byte layout
  localparam int          ACT_HI           = 7;
  localparam int          ACT_LO           = 6;
  localparam int          RETRY_HI         = 5;
  localparam int          RETRY_LO         = 3;
  localparam int          HICCUP_HI        = 2;
  localparam int          HICCUP_LO        = 0;
  localparam logic [2:0]  RETRY_LATCH      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER    = 3'h7;

  typedef enum logic [1:0] {
    ACT_IGNORE   = 2'b00,
    ACT_SHUT_A   = 2'b01,
    ACT_SHUT_B   = 2'b10,
    ACT_INVALID  = 2'b11
  } coovl_action_e;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_HICCUP  = 2'b01,
    ST_LATCHED = 2'b10
  } coovl_state_e;

  // thresholds kept in half-percent units: pct_x2 = 210 + 5 * step
  localparam logic [8:0]  PCT_BASE_X2      = 9'h0d2;
  localparam logic [8:0]  PCT_STEP_X2      = 9'h005;
  localparam logic [8:0]  PCT_SCALE_X2     = 9'h0c8;
  localparam int          OV_STEPS         = 15;
  localparam int          DIS_FIRST_STEP   = 2;
  localparam int          DIS_STRIDE       = 4;
  localparam logic [15:0] REL_ONE          = 16'h0200;

  function automatic logic [8:0] ov_pct_x2(input logic [3:0] step);
    ov_pct_x2 = 9'(PCT_BASE_X2 + PCT_STEP_X2 * step);
  endfunction : ov_pct_x2

  function automatic logic [25:0] mul26(input logic [15:0] a, input logic [8:0] b);
    mul26 = 26'({10'h000, a} * {17'h00000, b});
  endfunction : mul26
endpackage : coovl_pkg

// ==== src/coovl_trim_mem.sv ====
`timescale 1ns/100ps
module coovl_trim_mem
  import coovl_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int W     = 11
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [DEPTH-1:0]         i_wr_mask,
  input  wire logic signed [W-1:0]      i_wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic signed [W-1:0]           o_rd_data,
  output logic signed [W+1:0]           o_sum
);
  logic signed [W-1:0] mem [DEPTH];
  logic signed [W+1:0] next_sum;

  // one offset per phase, written independently [R1]
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) if (i_wr_mask[i]) mem[i] <= i_wr_data;
    end
  end

  always_comb begin
    next_sum = '0;
    for (int i = 0; i < DEPTH; i++) next_sum = next_sum + (W+2)'(mem[i]);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
      o_sum     <= '0;
    end else begin
      o_rd_data <= mem[i_rd_addr];
      o_sum     <= next_sum;
    end
  end
endmodule : coovl_trim_mem

// ==== src/coovl_ov_mapper.sv ====
`timescale 1ns/100ps
module coovl_ov_mapper
  import coovl_pkg::*;
(
  input  wire logic [15:0] i_limit,
  input  wire logic [15:0] i_vout_command,
  input  wire logic        i_relative,
  input  wire logic        i_conv_enabled,
  output logic [3:0]       o_step,
  output logic             o_out_of_range
);
  logic [25:0] num;
  logic [15:0] den;
  logic        found;
  logic        allowed;

  // limit/target ratio mapped up to the next hardware step [R15] [R16] [R17]
  always_comb begin
    num     = mul26(i_limit, PCT_SCALE_X2);
    den     = i_relative ? REL_ONE : i_vout_command;
    found   = 1'b0;
    allowed = 1'b0;
    o_step  = 4'(OV_STEPS - 1);
    for (int k = OV_STEPS - 1; k >= 0; k--) begin
      allowed = i_conv_enabled ||
                (k >= DIS_FIRST_STEP && ((k - DIS_FIRST_STEP) % DIS_STRIDE) == 0);
      if (allowed && num <= mul26(den, ov_pct_x2(4'(k)))) begin
        o_step = 4'(k);
        found  = 1'b1;
      end
    end
    o_out_of_range = !found || i_limit == 16'h0000 || den == 16'h0000; // [R4]
  end
endmodule : coovl_ov_mapper

// ==== src/coovl_regs.sv ====
`timescale 1ns/100ps
// What this block does
// R1: separate offset trim kept for every phase
// R2: stack offset is sum of all trims
// R3: trim word: exponent 15:11, mantissa 10:0
// R4: out-of-range writes rejected, invalid data flagged
// R5: restore loads quantised stored trim value
// R6: full-resolution trim writes accepted within range
// R7: single phase selects only that phase
// R8: all-phase write divides value by phases
// R9: all-phase read returns phase zero times count
// R10: overvoltage limit is unphased 16-bit word
// R11: threshold always relative to output command
// R12: command change leaves stored limit unchanged
// R13: overvoltage detection armed after power-on reset
// R14: fault triggers the configured response action
// R15: limit mapped to hardware percentage per mode
// R16: enabled: round up, 105-140% 2.5% steps
// R17: disabled: only 110-140% in 10% steps
// R18: action field: ignore, shutdown-retry, invalid
// R19: retry field: latch, 1-6 retries, endless
// R20: host sets phase selector before trim access
module coovl_regs
  import coovl_pkg::*;
#(
  parameter int          NUM_PHASES_MAX = 4,
  parameter int          QUANT_SHIFT    = 2,
  parameter logic signed [10:0] TRIM_MIN = 11'sh400,
  parameter logic signed [10:0] TRIM_MAX = 11'sh3ff,
  parameter logic [15:0] OV_LIMIT_RESET = 16'h02cd
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic        i_wr_stb,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_rd_stb,
  input  wire logic [7:0]  i_phase_sel,
  input  wire logic [2:0]  i_num_phases,
  input  wire logic        i_vout_relative,
  input  wire logic [15:0] i_vout_command,
  input  wire logic [15:0] i_vout_sense,
  input  wire logic        i_conv_enabled,
  input  wire logic        i_por_done,
  input  wire logic [7:0]  i_ov_response,
  input  wire logic [15:0] i_ton_rise_cycles,
  input  wire logic        i_clear_faults,
  input  wire logic        i_nvm_restore,
  input  wire logic [15:0] i_nvm_trim,
  input  wire logic [15:0] i_peer_offset_sum,
  output logic [15:0]      o_rd_data,
  output logic             o_rd_valid,
  output logic             o_invalid_data,
  output logic             o_ov_fault,
  output logic [3:0]       o_ov_step,
  output logic [15:0]      o_stack_offset,
  output logic             o_conv_inhibit,
  output logic             o_restart,
  output logic             o_latched_off
);
  localparam int AW = $clog2(NUM_PHASES_MAX);

  logic [1:0]                 rst_sync;
  logic                       rst_n;
  logic [15:0]                ov_limit;
  logic [NUM_PHASES_MAX-1:0]  trim_mask;
  logic signed [10:0]         trim_wdata;
  logic [AW-1:0]              trim_raddr;
  logic signed [10:0]         trim_rdata;
  logic signed [12:0]         trim_sum;
  logic [2:0]                 nph;
  logic                       sel_all;
  logic                       sel_ok;
  logic signed [11:0]         wr_man;
  logic signed [11:0]         wr_share;
  logic                       trim_wr;
  logic                       trim_ok;
  logic                       ov_wr;
  logic [3:0]                 live_step;
  logic                       live_oor;
  logic                       cand_oor;
  logic                       ov_detect;
  coovl_state_e               state;
  coovl_state_e               next_state;
  logic [2:0]                 attempts;
  logic [15:0]                ton_cnt;
  logic [2:0]                 mult_cnt;
  logic                       hiccup_done;
  logic [1:0]                 act;
  logic [2:0]                 retry;

  function automatic logic signed [10:0] sat11(input logic signed [15:0] v);
    if (v > 16'(TRIM_MAX))      sat11 = TRIM_MAX;
    else if (v < 16'(TRIM_MIN)) sat11 = TRIM_MIN;
    else                        sat11 = 11'(v);
  endfunction : sat11

  function automatic logic signed [11:0] div_phases(input logic signed [11:0] v,
                                                     input logic [2:0] n);
    case (n)
      3'h2:    div_phases = v / 12'sh2;
      3'h3:    div_phases = v / 12'sh3;
      3'h4:    div_phases = v / 12'sh4;
      default: div_phases = v;
    endcase
  endfunction : div_phases

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) rst_sync <= 2'b00;
    else            rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // decode of the phased trim access; writes to phases beyond the stack are refused
  assign nph      = (i_num_phases == 3'h0) ? 3'h1 : i_num_phases;
  assign sel_all  = i_phase_sel == PHASE_ALL;
  assign sel_ok   = sel_all || (i_phase_sel <= PHASE_LAST && i_phase_sel < {5'h00, nph}); // [R7]
  assign wr_man   = 12'(signed'(i_wr_data[TRIM_MAN_HI:0]));
  assign wr_share = sel_all ? div_phases(wr_man, nph) : wr_man; // [R8]
  assign trim_wr  = i_wr_stb && i_cmd_code == CMD_OFFSET_TRIM;
  assign ov_wr    = i_wr_stb && i_cmd_code == CMD_OV_LIMIT;
  // any exponent other than the fixed one is out of range [R3] [R6]
  assign trim_ok  = sel_ok && i_wr_data[TRIM_EXP_HI:TRIM_EXP_LO] == TRIM_EXP_FIXED &&
                    wr_share >= 12'(TRIM_MIN) && wr_share <= 12'(TRIM_MAX);
  assign trim_raddr = sel_all ? '0 : AW'(i_phase_sel); // [R9]

  always_comb begin
    trim_mask  = '0;
    trim_wdata = 11'(wr_share);
    if (i_nvm_restore) begin
      // nearest supported step; restore wins over a same-cycle write [R5]
      trim_mask  = '1;
      trim_wdata = sat11(16'(((16'(signed'(i_nvm_trim[TRIM_MAN_HI:0]))
                   + 16'sh2 ** (QUANT_SHIFT - 1)) >>> QUANT_SHIFT) <<< QUANT_SHIFT));
    end else if (trim_wr && trim_ok) begin
      for (int i = 0; i < NUM_PHASES_MAX; i++)
        trim_mask[i] = sel_all ? (i < int'(nph)) : (AW'(i) == AW'(i_phase_sel)); // [R7] [R8]
    end
  end

  coovl_trim_mem #(
    .DEPTH (NUM_PHASES_MAX),
    .W     (TRIM_MAN_W)
  ) u_trim_mem (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_wr_mask (trim_mask),
    .i_wr_data (trim_wdata),
    .i_rd_addr (trim_raddr),
    .o_rd_data (trim_rdata),
    .o_sum     (trim_sum)
  );

  // limit is stored as written; the mapper re-evaluates it every cycle [R10] [R12]
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n)                    ov_limit <= OV_LIMIT_RESET;
    else if (ov_wr && !cand_oor)   ov_limit <= i_wr_data; // [R4]
  end

  coovl_ov_mapper u_map_live (
    .i_limit        (ov_limit),
    .i_vout_command (i_vout_command),
    .i_relative     (i_vout_relative),
    .i_conv_enabled (i_conv_enabled),
    .o_step         (live_step),
    .o_out_of_range (live_oor)
  );

  coovl_ov_mapper u_map_cand (
    .i_limit        (i_wr_data),
    .i_vout_command (i_vout_command),
    .i_relative     (i_vout_relative),
    .i_conv_enabled (i_conv_enabled),
    .o_step         (),
    .o_out_of_range (cand_oor)
  );

  // a live limit that no longer maps keeps the top step as the safe choice
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_ov_step <= 4'(OV_STEPS - 1);
    else        o_ov_step <= live_oor ? 4'(OV_STEPS - 1) : live_step; // [R15] [R16] [R17]
  end

  // compare against percentage of the live command in any mode [R11] [R13]
  assign ov_detect = i_por_done &&
                     mul26(i_vout_sense, PCT_SCALE_X2) > mul26(i_vout_command, ov_pct_x2(o_ov_step));

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n)         o_ov_fault <= 1'b0;
    else if (ov_detect) o_ov_fault <= 1'b1;
    else if (i_clear_faults) o_ov_fault <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rd_data  <= '0;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        case (i_cmd_code)
          CMD_OFFSET_TRIM: o_rd_data <= {TRIM_EXP_FIXED,
                           sel_all ? sat11(16'(trim_rdata) * 16'(nph)) : trim_rdata}; // [R9]
          CMD_OV_LIMIT:    o_rd_data <= ov_limit; // [R10]
          default:         o_rd_data <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_invalid_data <= 1'b0;
    else        o_invalid_data <= (trim_wr && !trim_ok) || (ov_wr && cand_oor); // [R4]
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_stack_offset <= '0;
    else        o_stack_offset <= 16'(trim_sum) + i_peer_offset_sum; // [R2]
  end

  // fault response engine
  assign act   = i_ov_response[ACT_HI:ACT_LO];
  assign retry = i_ov_response[RETRY_HI:RETRY_LO];
  assign hiccup_done = ton_cnt >= i_ton_rise_cycles &&
                       mult_cnt >= i_ov_response[HICCUP_HI:HICCUP_LO];

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // ignore keeps running; invalid code treated as shutdown for safety [R14] [R18]
        if (ov_detect && coovl_action_e'(act) != ACT_IGNORE) begin
          if (retry == RETRY_LATCH || (retry != RETRY_FOREVER && attempts >= retry))
            next_state = ST_LATCHED; // [R19]
          else
            next_state = ST_HICCUP;
        end
      end
      ST_HICCUP:  if (hiccup_done) next_state = ST_RUN;
      ST_LATCHED: if (!i_conv_enabled) next_state = ST_RUN;
      default:    next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) state <= ST_RUN;
    else        state <= next_state;
  end

  // hiccup lasts (multiple + 1) ton_rise periods
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ton_cnt  <= '0;
      mult_cnt <= '0;
    end else if (state != ST_HICCUP) begin
      ton_cnt  <= '0;
      mult_cnt <= '0;
    end else if (ton_cnt >= i_ton_rise_cycles) begin
      ton_cnt  <= '0;
      mult_cnt <= mult_cnt + 3'h1;
    end else begin
      ton_cnt  <= ton_cnt + 16'h0001;
    end
  end

  // attempt count clears only when the output is commanded off
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n)                                attempts <= '0;
    else if (!i_conv_enabled)                  attempts <= '0;
    else if (state == ST_HICCUP && hiccup_done && attempts != RETRY_FOREVER)
      attempts <= attempts + 3'h1; // [R19]
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_conv_inhibit <= 1'b0;
      o_restart      <= 1'b0;
      o_latched_off  <= 1'b0;
    end else begin
      o_conv_inhibit <= next_state != ST_RUN; // [R14]
      o_restart      <= state == ST_HICCUP && next_state == ST_RUN;
      o_latched_off  <= next_state == ST_LATCHED;
    end
  end
endmodule : coovl_regs

// ==== test/coovl_host.sv ====
`timescale 1ns/100ps
module coovl_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_invalid_data,
  output logic [7:0]       o_cmd_code,
  output logic             o_wr_stb,
  output logic             o_rd_stb,
  output logic [15:0]      o_wr_data,
  output logic [7:0]       o_phase_sel
);
  initial begin
    o_cmd_code  = 8'h00;
    o_wr_stb    = 1'b0;
    o_rd_stb    = 1'b0;
    o_wr_data   = 16'h0000;
    o_phase_sel = 8'h00;
  end

  // one access; phase settles a cycle early because trim reads are registered
  task automatic acc(input logic wr, input logic [7:0] cmd, input logic [7:0] ph,
                     input logic [15:0] d, output logic [15:0] q);
    o_phase_sel = ph;
    @(negedge i_clk);
    o_cmd_code = cmd;
    o_wr_data  = d;
    o_wr_stb   = wr;
    o_rd_stb   = !wr;
    @(negedge i_clk);
    q = wr ? {15'h0000, i_invalid_data} : i_rd_data;
    o_wr_stb  = 1'b0;
    o_rd_stb  = 1'b0;
    o_wr_data = ~d;
    repeat (2) @(negedge i_clk);
  endtask : acc
endmodule : coovl_host

// ==== test/coovl_regs_chk.sv ====
`timescale 1ns/100ps
module coovl_regs_chk
  import coovl_pkg::*;
#(
  parameter logic [15:0] OV_LIMIT_RESET = 16'h02cd
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic        i_wr_stb,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_rd_stb,
  input  wire logic [15:0] i_vout_command,
  input  wire logic [15:0] i_vout_sense,
  input  wire logic        i_conv_enabled,
  input  wire logic        i_por_done,
  input  wire logic [7:0]  i_ov_response,
  input  wire logic [15:0] o_rd_data,
  input  wire logic        o_rd_valid,
  input  wire logic        o_invalid_data,
  input  wire logic        o_ov_fault,
  input  wire logic [3:0]  o_ov_step,
  input  wire logic        o_conv_inhibit,
  input  wire logic        o_latched_off
);
  logic        ov_hit;
  logic        pend_w;
  logic [15:0] pend_d;
  logic [15:0] shadow;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  assign ov_hit = i_por_done && (({10'h000, i_vout_sense} * 26'h0c8) >
                  ({10'h000, i_vout_command} * (26'h0d2 + 26'h005 * {22'h0, o_ov_step})));

  // shadow of the limit, updated only once the write was not refused
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_w <= 1'b0;
      pend_d <= 16'h0000;
      shadow <= OV_LIMIT_RESET;
    end else begin
      pend_w <= i_wr_stb && (i_cmd_code == CMD_OV_LIMIT);
      pend_d <= i_wr_data;
      if (pend_w && !o_invalid_data) begin
        shadow <= pend_d;
      end
    end
  end

  rd_answer_a: assert property (i_rd_stb |=> o_rd_valid)
    else $error("read not answered next cycle");
  invalid_src_a: assert property (o_invalid_data |-> $past(i_wr_stb))
    else $error("invalid flag without a write");
  ov_read_a: assert property (i_rd_stb && i_cmd_code == CMD_OV_LIMIT && !pend_w
    |=> o_rd_data == shadow) else $error("limit read differs from stored word");
  por_arm_a: assert property (!i_por_done && !o_ov_fault |=> !o_ov_fault)
    else $error("fault before power-on reset done");
  fault_set_a: assert property (ov_hit |=> o_ov_fault)
    else $error("overvoltage not flagged");
  stop_taken_a: assert property (ov_hit && i_ov_response[7:6] != 2'b00 |=> o_conv_inhibit)
    else $error("shutdown action not taken");
  ignore_runs_a: assert property (ov_hit && i_ov_response[7:6] == 2'b00 && !o_conv_inhibit
    |=> !o_conv_inhibit) else $error("ignore action shut down");
  latch_now_a: assert property (ov_hit && i_ov_response[7:6] != 2'b00
    && i_ov_response[5:3] == 3'h0 && !o_conv_inhibit |=> o_latched_off)
    else $error("retry zero did not latch off");
  dis_steps_a: assert property (!i_conv_enabled && $past(!i_conv_enabled)
    |-> o_ov_step[1:0] == 2'b10) else $error("disabled step not a 10 percent step");
  step_max_a: assert property (o_ov_step <= 4'he)
    else $error("step above 140 percent");
endmodule : coovl_regs_chk

bind coovl_regs coovl_regs_chk #(.OV_LIMIT_RESET(OV_LIMIT_RESET)) u_coovl_regs_chk (
  .i_clk, .i_reset_n, .i_cmd_code, .i_wr_stb, .i_wr_data, .i_rd_stb, .i_vout_command,
  .i_vout_sense, .i_conv_enabled, .i_por_done, .i_ov_response, .o_rd_data, .o_rd_valid,
  .o_invalid_data, .o_ov_fault, .o_ov_step, .o_conv_inhibit, .o_latched_off);

// ==== test/test_coovl_regs.sv ====
`timescale 1ns/100ps
module test_coovl_regs
  import coovl_pkg::*;
;
  localparam logic [15:0] OVR = 16'h02cd;
  logic        i_clk, i_reset_n, rel, en, por, clr, nvm_ld, wstb, rstb;
  logic        rv, inv, flt, inh, rs, lat, seen;
  logic [2:0]  nph;
  logic [3:0]  step;
  logic [7:0]  resp, cmd, ph;
  logic [10:0] man [4];
  logic [15:0] vcmd, sense, ton, nvm, peer, wrd, rdd, stack, q;
  int          n_fail, compares, n_rv;

  coovl_regs #(.OV_LIMIT_RESET(OVR)) u_coovl_regs (
    .i_clk, .i_reset_n, .i_cmd_code(cmd), .i_wr_stb(wstb), .i_wr_data(wrd),
    .i_rd_stb(rstb), .i_phase_sel(ph), .i_num_phases(nph), .i_vout_relative(rel),
    .i_vout_command(vcmd), .i_vout_sense(sense), .i_conv_enabled(en), .i_por_done(por),
    .i_ov_response(resp), .i_ton_rise_cycles(ton), .i_clear_faults(clr),
    .i_nvm_restore(nvm_ld), .i_nvm_trim(nvm), .i_peer_offset_sum(peer), .o_rd_data(rdd),
    .o_rd_valid(rv), .o_invalid_data(inv), .o_ov_fault(flt), .o_ov_step(step),
    .o_stack_offset(stack), .o_conv_inhibit(inh), .o_restart(rs), .o_latched_off(lat));
  coovl_host u_coovl_host (.i_clk, .i_rd_data(rdd), .i_invalid_data(inv), .o_cmd_code(cmd),
    .o_wr_stb(wstb), .o_rd_stb(rstb), .o_wr_data(wrd), .o_phase_sel(ph));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // every read must be answered by exactly one valid pulse
  always @(negedge i_clk) begin
    if (rv) n_rv++;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
    u_coovl_host.acc(1'b0, c, p, 16'h0000, q);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
                    input logic bad);
    u_coovl_host.acc(1'b1, c, p, d, q);
    chk(q, {15'h0000, bad});
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    {i_reset_n, por, clr, nvm_ld} = 4'h0;
    {rel, en} = 2'b11;
    nph = 3'h4;
    vcmd = 16'h1000;
    sense = 16'h0000;
    ton = 16'h0003;
    nvm = 16'h0000;
    peer = 16'h0005;
    resp = 8'h00;
    man = '{11'h001, 11'h002, 11'h003, 11'h7fc};
    tick(4);
    i_reset_n = 1'b1;
    tick(3);
    rd(CMD_OV_LIMIT, 8'h00, OVR);
    rd(CMD_OFFSET_TRIM, 8'h00, {TRIM_EXP_FIXED, 11'h000});
    $display("test reset done");
    for (int p = 0; p < 4; p++) wr(CMD_OFFSET_TRIM, 8'(p), {TRIM_EXP_FIXED, man[p]}, 1'b0);
    for (int p = 0; p < 4; p++) rd(CMD_OFFSET_TRIM, 8'(p), {TRIM_EXP_FIXED, man[p]});
    chk(stack, 16'h0007);
    rd(CMD_OFFSET_TRIM, PHASE_ALL, {TRIM_EXP_FIXED, 11'h004});
    wr(CMD_OFFSET_TRIM, PHASE_ALL, {TRIM_EXP_FIXED, 11'h7f7}, 1'b0);
    rd(CMD_OFFSET_TRIM, 8'h01, {TRIM_EXP_FIXED, 11'h7fe});
    $display("test phases done");
    wr(CMD_OFFSET_TRIM, 8'h00, 16'h0001, 1'b1);
    wr(CMD_OFFSET_TRIM, 8'h04, {TRIM_EXP_FIXED, 11'h001}, 1'b1);
    wr(CMD_OV_LIMIT, 8'h00, 16'h0000, 1'b1);
    wr(CMD_OV_LIMIT, 8'h00, 16'h0300, 1'b1);
    rd(CMD_OFFSET_TRIM, 8'h00, {TRIM_EXP_FIXED, 11'h7fe});
    wr(CMD_OFFSET_TRIM, 8'h00, {TRIM_EXP_FIXED, 11'h3ff}, 1'b0);
    rd(CMD_OFFSET_TRIM, 8'h00, {TRIM_EXP_FIXED, 11'h3ff});
    nvm = {TRIM_EXP_FIXED, 11'h007};
    nvm_ld = 1'b1;
    tick(1);
    nvm_ld = 1'b0;
    tick(2);
    rd(CMD_OFFSET_TRIM, 8'h02, {TRIM_EXP_FIXED, 11'h008});
    nph = 3'h3;
    wr(CMD_OFFSET_TRIM, PHASE_ALL, {TRIM_EXP_FIXED, 11'h7f7}, 1'b0);
    rd(CMD_OFFSET_TRIM, 8'h02, {TRIM_EXP_FIXED, 11'h7fd});
    rd(CMD_OFFSET_TRIM, 8'h03, {TRIM_EXP_FIXED, 11'h008});
    rd(CMD_OFFSET_TRIM, PHASE_ALL, {TRIM_EXP_FIXED, 11'h7f7});
    nph = 3'h4;
    $display("test trim refusal and restore done");
    wr(CMD_OV_LIMIT, 8'h00, 16'h0233, 1'b0);
    chk({12'h000, step}, 16'h0002);
    wr(CMD_OV_LIMIT, 8'h00, 16'h0250, 1'b0);
    chk({12'h000, step}, 16'h0005);
    en = 1'b0;
    tick(3);
    chk({12'h000, step}, 16'h0006);
    en = 1'b1;
    rel = 1'b0;
    wr(CMD_OV_LIMIT, 8'h00, 16'h1200, 1'b0);
    chk({12'h000, step}, 16'h0003);
    vcmd = 16'h0c00;
    tick(2);
    rd(CMD_OV_LIMIT, 8'h00, 16'h1200);
    vcmd = 16'h1000;
    rel = 1'b1;
    $display("test limit mapping done");
    wr(CMD_OV_LIMIT, 8'h00, 16'h0240, 1'b0);
    sense = 16'h1400;
    tick(3);
    chk({15'h0000, flt}, 16'h0000);
    por = 1'b1;
    tick(2);
    chk({14'h0000, flt, inh}, 16'h0002);
    sense = 16'h0000;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(1);
    chk({15'h0000, flt}, 16'h0000);
    resp = 8'h78;
    sense = 16'h1400;
    tick(1);
    sense = 16'h0000;
    tick(1);
    chk({15'h0000, inh}, 16'h0001);
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(posedge i_clk);
      #1 seen = rs;
    end
    tick(1);
    chk({14'h0000, seen, inh}, 16'h0002);
    resp = 8'h80;
    sense = 16'h1400;
    tick(2);
    chk({14'h0000, lat, inh}, 16'h0003);
    sense = 16'h0000;
    // one allowed restart, then the second fault latches off
    en = 1'b0;
    tick(2);
    en = 1'b1;
    resp = 8'h48;
    sense = 16'h1400;
    tick(1);
    sense = 16'h0000;
    tick(6);
    chk({14'h0000, lat, inh}, 16'h0000);
    sense = 16'h1400;
    tick(2);
    chk({14'h0000, lat, inh}, 16'h0003);
    sense = 16'h0000;
    chk(16'(n_rv), 16'h000f);
    $display("test fault response done");
    finish_test();
  end
endmodule : test_coovl_regs
